/* File: core/rsd_defines.vh */
`ifndef RSD_DEFINES_VH
`define RSD_DEFINES_VH

// direct space split
`define RSD_LOWER_TOP      8'h7f
`define RSD_REG_BASE       8'h80
// bit-addressable scratchpad bytes
`define RSD_BIT_RAM_BASE   8'h20
`define RSD_BIT_RAM_COUNT  8'h80
// special-function register offsets held here
`define RSD_STACK_PTR_ADDR 8'h81
`define RSD_PSW_ADDR       8'hd0
`define RSD_STACK_EXT_ADDR 8'h9b
`define RSD_ADDR_CTRL_ADDR 8'h9d
`define RSD_MEM_CTRL_ADDR  8'hc6
// held general registers
`define RSD_PORT4_LATCH_ADDR   8'h80
`define RSD_DATA_PTR0_LO_ADDR  8'h82
`define RSD_DATA_PTR0_HI_ADDR  8'h83
`define RSD_DATA_PTR1_LO_ADDR  8'h84
`define RSD_DATA_PTR1_HI_ADDR  8'h85
`define RSD_PTR_SELECT_ADDR    8'h86
`define RSD_POWER_CTRL_ADDR    8'h87
`define RSD_TIMER01_CTRL_ADDR  8'h88
`define RSD_TIMER01_MODE_ADDR  8'h89
`define RSD_TIMER0_LO_ADDR     8'h8a
`define RSD_TIMER1_LO_ADDR     8'h8b
`define RSD_TIMER0_HI_ADDR     8'h8c
`define RSD_TIMER1_HI_ADDR     8'h8d
`define RSD_CLK_DIV_ADDR       8'h8e
`define RSD_PORT1_LATCH_ADDR   8'h90
`define RSD_EXT_IRQ_ADDR       8'h91
`define RSD_PORT4_FUNC_ADDR    8'h92
`define RSD_DATA_PTR0_EXT_ADDR 8'h93
`define RSD_DATA_PTR1_EXT_ADDR 8'h95
`define RSD_CAN_MASK0_ADDR     8'h96
`define RSD_CAN_MASK1_ADDR     8'h97
// fields
`define RSD_PSW_BANK_LSB   3
`define RSD_ADDR_CTRL_BIGSTK 2
`define RSD_MCON_MAP_LSB   6
// reset values
`define RSD_STACK_PTR_RST  8'h07
`define RSD_ZERO_BYTE      8'h00
// access kinds
`define RSD_ACC_DIRECT     2'h0
`define RSD_ACC_INDIRECT   2'h1
`define RSD_ACC_BIT        2'h2
`define RSD_ACC_WORKREG    2'h3
// stack operations
`define RSD_STK_NONE       2'h0
`define RSD_STK_PUSH       2'h1
`define RSD_STK_POP        2'h2

`endif

/* File: core/rsd_register_space.v */
// What this block does
// - direct address 00h-7Fh selects the matching scratchpad byte
// - direct address 80h-FFh always selects a special-function register
// - indirect address 80h-FFh reaches upper scratchpad bytes, not registers
// - 256 scratchpad bytes plus up to 128 special-function registers
// - bytes 20h-2Fh give 128 individually addressable bits
// - registers ending in hex 0 or 8 also allow single-bit access
// - instruction kind, not address, picks bit or byte access
// - four banks of eight working registers chosen by status word bank bits
// - working register contents serve as indirect addresses, upper RAM included
// - call or interrupt entry pushes the return address on the stack
// - stack pointer resets to 07h at 81h and software may rewrite it
// - pointer marks last used entry; push pre-increments, pop reads then decrements
// - big-stack enable moves the stack into 1kB of internal SRAM
// - big-stack address is extension bits 1:0 above the 8-bit pointer
// - big-stack base follows the internal memory map select bits
// - pointer and extension address a dedicated 1kB SRAM stack area
`include "rsd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module rsd_register_space (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// core access request
	input  wire        acc_valid,
	input  wire [1:0]  acc_kind,
	input  wire        acc_write,
	input  wire [7:0]  acc_addr,
	input  wire [2:0]  acc_bit,
	input  wire        acc_wbit,
	input  wire [7:0]  acc_wdata,
	input  wire        acc_via_reg,
	// stack request
	input  wire [1:0]  stk_op,
	input  wire [7:0]  stk_wdata,
	// sram stack port
	input  wire [7:0]  sram_rdata,
	output reg         sram_en,
	output reg         sram_we,
	output reg  [15:0] sram_addr,
	output reg  [7:0]  sram_wdata,
	// answers
	output reg  [7:0]  rd_data,
	output reg         rd_bit,
	output reg         rd_valid,
	output reg  [7:0]  stack_pointer,
	output reg  [1:0]  stack_ext
);
	parameter [15:0] MAP_BASE0 = 16'h0000;
	parameter [15:0] MAP_BASE1 = 16'h0400;
	parameter [15:0] MAP_BASE2 = 16'h1000;
	parameter [15:0] MAP_BASE3 = 16'h2000;

	reg  [7:0]  ram_r [0:255];
	reg  [7:0]  stk_ptr_r;
	reg  [7:0]  stk_ptr_nxt;
	reg  [7:0]  stk_ptr_inc;
	reg  [1:0]  stk_ext_r;
	reg  [1:0]  stk_ext_nxt;
	reg  [7:0]  psw_r;
	reg  [7:0]  addr_ctrl_r;
	reg  [7:0]  mcon_r;
	reg  [7:0]  reg_rd;
	reg         reg_hit;
	reg  [7:0]  eff_addr;
	reg         to_ram;
	reg         bit_ok;
	reg  [7:0]  ram_idx;
	reg  [7:0]  old_byte;
	reg  [7:0]  new_byte;
	reg  [7:0]  bit_byte;
	reg         pop_pend_r;
	reg         pop_wait_r;
	reg  [15:0] stk_base;
	wire        big_stk;
	wire [4:0]  reg_slot;
	wire [7:0]  reg_ptr;
	// held general registers
	reg  [7:0]  port4_latch_r;
	reg  [7:0]  data_ptr0_lo_r;
	reg  [7:0]  data_ptr0_hi_r;
	reg  [7:0]  data_ptr1_lo_r;
	reg  [7:0]  data_ptr1_hi_r;
	reg  [7:0]  ptr_select_r;
	reg  [7:0]  power_ctrl_r;
	reg  [7:0]  timer01_ctrl_r;
	reg  [7:0]  timer01_mode_r;
	reg  [7:0]  timer0_lo_r;
	reg  [7:0]  timer1_lo_r;
	reg  [7:0]  timer0_hi_r;
	reg  [7:0]  timer1_hi_r;
	reg  [7:0]  clk_div_r;
	reg  [7:0]  port1_latch_r;
	reg  [7:0]  ext_irq_r;
	reg  [7:0]  port4_func_r;
	reg  [7:0]  data_ptr0_ext_r;
	reg  [7:0]  data_ptr1_ext_r;
	reg  [7:0]  can_mask0_r;
	reg  [7:0]  can_mask1_r;

	assign big_stk = addr_ctrl_r[`RSD_ADDR_CTRL_BIGSTK];
	// working register slot inside the selected bank
	assign reg_slot = {psw_r[`RSD_PSW_BANK_LSB+1:`RSD_PSW_BANK_LSB], acc_addr[2:0]};
	assign reg_ptr = ram_r[{3'h0, reg_slot}];

	// effective byte and target selection
	always @* begin
		eff_addr = acc_addr;
		to_ram = 1'b0;
		bit_ok = 1'b0;
		bit_byte = acc_addr;
		case (acc_kind)
			`RSD_ACC_DIRECT: begin
				to_ram = (acc_addr <= `RSD_LOWER_TOP);
			end
			`RSD_ACC_INDIRECT: begin
				if (acc_via_reg)
					eff_addr = reg_ptr;
				to_ram = 1'b1;
			end
			`RSD_ACC_BIT: begin
				if (acc_addr < `RSD_BIT_RAM_COUNT) begin
					bit_byte = `RSD_BIT_RAM_BASE + {4'h0, acc_addr[6:3]};
					to_ram = 1'b1;
					bit_ok = 1'b1;
				end else begin
					bit_byte = {acc_addr[7:3], 3'h0};
					bit_ok = 1'b1;
				end
				eff_addr = bit_byte;
			end
			`RSD_ACC_WORKREG: begin
				eff_addr = {3'h0, reg_slot};
				to_ram = 1'b1;
			end
			default: begin
				to_ram = 1'b0;
			end
		endcase
		ram_idx = eff_addr;
	end

	// register read mux
	always @* begin
		reg_hit = 1'b1;
		case (eff_addr)
			`RSD_STACK_PTR_ADDR:     reg_rd = stk_ptr_r;
			`RSD_PSW_ADDR:           reg_rd = psw_r;
			`RSD_STACK_EXT_ADDR:     reg_rd = {6'h00, stk_ext_r};
			`RSD_ADDR_CTRL_ADDR:     reg_rd = addr_ctrl_r;
			`RSD_MEM_CTRL_ADDR:      reg_rd = mcon_r;
			// ports and pointers
			`RSD_PORT4_LATCH_ADDR:   reg_rd = port4_latch_r;
			`RSD_DATA_PTR0_LO_ADDR:  reg_rd = data_ptr0_lo_r;
			`RSD_DATA_PTR0_HI_ADDR:  reg_rd = data_ptr0_hi_r;
			`RSD_DATA_PTR1_LO_ADDR:  reg_rd = data_ptr1_lo_r;
			`RSD_DATA_PTR1_HI_ADDR:  reg_rd = data_ptr1_hi_r;
			`RSD_PTR_SELECT_ADDR:    reg_rd = ptr_select_r;
			`RSD_POWER_CTRL_ADDR:    reg_rd = power_ctrl_r;
			// timers
			`RSD_TIMER01_CTRL_ADDR:  reg_rd = timer01_ctrl_r;
			`RSD_TIMER01_MODE_ADDR:  reg_rd = timer01_mode_r;
			`RSD_TIMER0_LO_ADDR:     reg_rd = timer0_lo_r;
			`RSD_TIMER1_LO_ADDR:     reg_rd = timer1_lo_r;
			`RSD_TIMER0_HI_ADDR:     reg_rd = timer0_hi_r;
			`RSD_TIMER1_HI_ADDR:     reg_rd = timer1_hi_r;
			`RSD_CLK_DIV_ADDR:       reg_rd = clk_div_r;
			// second port group and extensions
			`RSD_PORT1_LATCH_ADDR:   reg_rd = port1_latch_r;
			`RSD_EXT_IRQ_ADDR:       reg_rd = ext_irq_r;
			`RSD_PORT4_FUNC_ADDR:    reg_rd = port4_func_r;
			`RSD_DATA_PTR0_EXT_ADDR: reg_rd = data_ptr0_ext_r;
			`RSD_DATA_PTR1_EXT_ADDR: reg_rd = data_ptr1_ext_r;
			`RSD_CAN_MASK0_ADDR:     reg_rd = can_mask0_r;
			`RSD_CAN_MASK1_ADDR:     reg_rd = can_mask1_r;
			default: begin
				reg_rd = `RSD_ZERO_BYTE;
				reg_hit = 1'b0;
			end
		endcase
	end

	// byte seen by the access and the byte it would write back
	always @* begin
		old_byte = to_ram ? ram_r[ram_idx] : reg_rd;
		new_byte = acc_wdata;
		if (acc_kind == `RSD_ACC_BIT) begin
			new_byte = old_byte;
			new_byte[acc_bit] = acc_wbit;
		end
	end

	// stack address generation
	always @* begin
		case (mcon_r[`RSD_MCON_MAP_LSB+1:`RSD_MCON_MAP_LSB])
			2'h0: stk_base = MAP_BASE0;
			2'h1: stk_base = MAP_BASE1;
			2'h2: stk_base = MAP_BASE2;
			default: stk_base = MAP_BASE3;
		endcase
		stk_ptr_inc = stk_ptr_r + 8'h01;
		stk_ptr_nxt = stk_ptr_r;
		stk_ext_nxt = stk_ext_r;
		// software rewrite of the pointer pair
		if (acc_valid && acc_write && !to_ram) begin
			if (eff_addr == `RSD_STACK_PTR_ADDR)
				stk_ptr_nxt = new_byte;
			if (eff_addr == `RSD_STACK_EXT_ADDR)
				stk_ext_nxt = new_byte[1:0];
		end
		// a stack operation wins over a pointer rewrite in the same cycle
		if (stk_op == `RSD_STK_PUSH) begin
			stk_ptr_nxt = stk_ptr_inc;
			if (big_stk && stk_ptr_r == 8'hff)
				stk_ext_nxt = stk_ext_r + 2'h1;
		end else if (stk_op == `RSD_STK_POP) begin
			stk_ptr_nxt = stk_ptr_r - 8'h01;
			if (big_stk && stk_ptr_r == 8'h00)
				stk_ext_nxt = stk_ext_r - 2'h1;
		end
	end

	// scratchpad storage
	genvar gi;
	generate
		for (gi = 0; gi < 256; gi = gi + 1) begin : g_ram
			always @(posedge clk) begin
				if (rst)
					ram_r[gi] <= `RSD_ZERO_BYTE;
				else if (stk_op == `RSD_STK_PUSH && !big_stk && stk_ptr_inc == gi)
					ram_r[gi] <= stk_wdata;
				else if (acc_valid && acc_write && to_ram && ram_idx == gi &&
					(acc_kind != `RSD_ACC_BIT || bit_ok))
					ram_r[gi] <= new_byte;
			end
		end
	endgenerate

	// stack pointer pair and control registers
	always @(posedge clk) begin
		if (rst) begin
			stk_ptr_r <= `RSD_STACK_PTR_RST;
			stk_ext_r <= 2'h0;
			psw_r <= `RSD_ZERO_BYTE;
			addr_ctrl_r <= `RSD_ZERO_BYTE;
			mcon_r <= `RSD_ZERO_BYTE;
			pop_pend_r <= 1'b0;
			pop_wait_r <= 1'b0;
		end else begin
			stk_ptr_r <= stk_ptr_nxt;
			stk_ext_r <= stk_ext_nxt;
			// sram read data arrives one cycle after its strobe
			pop_pend_r <= (stk_op == `RSD_STK_POP) && big_stk;
			pop_wait_r <= pop_pend_r;
			if (acc_valid && acc_write && !to_ram && reg_hit) begin
				case (eff_addr)
					`RSD_PSW_ADDR:       psw_r <= new_byte;
					`RSD_ADDR_CTRL_ADDR: addr_ctrl_r <= new_byte;
					`RSD_MEM_CTRL_ADDR:  mcon_r <= new_byte;
					default:             psw_r <= psw_r;
				endcase
			end
		end
	end

	// general registers held for the core
	always @(posedge clk) begin
		if (rst) begin
			// ports and pointers
			port4_latch_r <= `RSD_ZERO_BYTE;
			data_ptr0_lo_r <= `RSD_ZERO_BYTE;
			data_ptr0_hi_r <= `RSD_ZERO_BYTE;
			data_ptr1_lo_r <= `RSD_ZERO_BYTE;
			data_ptr1_hi_r <= `RSD_ZERO_BYTE;
			ptr_select_r <= `RSD_ZERO_BYTE;
			power_ctrl_r <= `RSD_ZERO_BYTE;
			// timers
			timer01_ctrl_r <= `RSD_ZERO_BYTE;
			timer01_mode_r <= `RSD_ZERO_BYTE;
			timer0_lo_r <= `RSD_ZERO_BYTE;
			timer1_lo_r <= `RSD_ZERO_BYTE;
			timer0_hi_r <= `RSD_ZERO_BYTE;
			timer1_hi_r <= `RSD_ZERO_BYTE;
			clk_div_r <= `RSD_ZERO_BYTE;
			// second port group and extensions
			port1_latch_r <= `RSD_ZERO_BYTE;
			ext_irq_r <= `RSD_ZERO_BYTE;
			port4_func_r <= `RSD_ZERO_BYTE;
			data_ptr0_ext_r <= `RSD_ZERO_BYTE;
			data_ptr1_ext_r <= `RSD_ZERO_BYTE;
			can_mask0_r <= `RSD_ZERO_BYTE;
			can_mask1_r <= `RSD_ZERO_BYTE;
		end else if (acc_valid && acc_write && !to_ram && reg_hit) begin
			case (eff_addr)
				// ports and pointers
				`RSD_PORT4_LATCH_ADDR:   port4_latch_r <= new_byte;
				`RSD_DATA_PTR0_LO_ADDR:  data_ptr0_lo_r <= new_byte;
				`RSD_DATA_PTR0_HI_ADDR:  data_ptr0_hi_r <= new_byte;
				`RSD_DATA_PTR1_LO_ADDR:  data_ptr1_lo_r <= new_byte;
				`RSD_DATA_PTR1_HI_ADDR:  data_ptr1_hi_r <= new_byte;
				`RSD_PTR_SELECT_ADDR:    ptr_select_r <= new_byte;
				`RSD_POWER_CTRL_ADDR:    power_ctrl_r <= new_byte;
				// timers
				`RSD_TIMER01_CTRL_ADDR:  timer01_ctrl_r <= new_byte;
				`RSD_TIMER01_MODE_ADDR:  timer01_mode_r <= new_byte;
				`RSD_TIMER0_LO_ADDR:     timer0_lo_r <= new_byte;
				`RSD_TIMER1_LO_ADDR:     timer1_lo_r <= new_byte;
				`RSD_TIMER0_HI_ADDR:     timer0_hi_r <= new_byte;
				`RSD_TIMER1_HI_ADDR:     timer1_hi_r <= new_byte;
				`RSD_CLK_DIV_ADDR:       clk_div_r <= new_byte;
				// second port group and extensions
				`RSD_PORT1_LATCH_ADDR:   port1_latch_r <= new_byte;
				`RSD_EXT_IRQ_ADDR:       ext_irq_r <= new_byte;
				`RSD_PORT4_FUNC_ADDR:    port4_func_r <= new_byte;
				`RSD_DATA_PTR0_EXT_ADDR: data_ptr0_ext_r <= new_byte;
				`RSD_DATA_PTR1_EXT_ADDR: data_ptr1_ext_r <= new_byte;
				`RSD_CAN_MASK0_ADDR:     can_mask0_r <= new_byte;
				`RSD_CAN_MASK1_ADDR:     can_mask1_r <= new_byte;
				default:                 port4_latch_r <= port4_latch_r;
			endcase
		end
	end

	// answers and sram stack port
	always @(posedge clk) begin
		if (rst) begin
			rd_data <= `RSD_ZERO_BYTE;
			rd_bit <= 1'b0;
			rd_valid <= 1'b0;
			sram_en <= 1'b0;
			sram_we <= 1'b0;
			sram_addr <= 16'h0000;
			sram_wdata <= `RSD_ZERO_BYTE;
			stack_pointer <= `RSD_STACK_PTR_RST;
			stack_ext <= 2'h0;
		end else begin
			// pointer outputs show the updated pair one cycle after an operation
			stack_pointer <= stk_ptr_nxt;
			stack_ext <= stk_ext_nxt;
			rd_valid <= 1'b0;
			sram_en <= 1'b0;
			sram_we <= 1'b0;
			if (acc_valid && !acc_write) begin
				rd_valid <= 1'b1;
				rd_data <= old_byte;
				rd_bit <= bit_ok & old_byte[acc_bit];
			end else if (stk_op == `RSD_STK_POP && !big_stk) begin
				rd_valid <= 1'b1;
				rd_data <= ram_r[stk_ptr_r];
				rd_bit <= 1'b0;
			end else if (pop_wait_r) begin
				rd_valid <= 1'b1;
				rd_data <= sram_rdata;
				rd_bit <= 1'b0;
			end
			if (big_stk && stk_op != `RSD_STK_NONE) begin
				sram_en <= 1'b1;
				sram_we <= (stk_op == `RSD_STK_PUSH);
				sram_wdata <= stk_wdata;
				// push writes at the new top, pop reads the current top
				if (stk_op == `RSD_STK_PUSH)
					sram_addr <= stk_base + {6'h00, stk_ext_nxt, stk_ptr_nxt};
				else
					sram_addr <= stk_base + {6'h00, stk_ext_r, stk_ptr_r};
			end
		end
	end
endmodule // rsd_register_space
`default_nettype wire

/* File: tb/rsd_space_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rsd_space_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// requests
	input wire logic        acc_valid,
	input wire logic        acc_write,
	input wire logic [1:0]  stk_op,
	// answers
	input wire logic        sram_en,
	input wire logic        sram_we,
	input wire logic [15:0] sram_addr,
	input wire logic        rd_valid,
	input wire logic [7:0]  stack_pointer,
	input wire logic [1:0]  stack_ext
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_big_pop;
		stk_op == 2'h2 ##1 sram_en && !sram_we;
	endsequence
	chk_sp_reset: assert property (
		$fell(rst) |-> stack_pointer == 8'h07) else $error("stack pointer reset value");
	chk_push_inc: assert property (
		stk_op == 2'h1 |=> stack_pointer == $past(stack_pointer) + 8'h01)
		else $error("push pointer step");
	chk_pop_dec: assert property (
		stk_op == 2'h2 |=> stack_pointer == $past(stack_pointer) - 8'h01)
		else $error("pop pointer step");
	chk_read_ans: assert property (
		acc_valid && !acc_write |=> rd_valid) else $error("read unanswered");
	chk_ans_cause: assert property (
		rd_valid |-> $past(acc_valid && !acc_write) || $past(stk_op == 2'h2)
		|| $past(stk_op == 2'h2, 3)) else $error("stray answer");
	chk_push_addr: assert property (
		sram_en && sram_we |-> sram_addr[9:0] == {stack_ext, stack_pointer})
		else $error("big stack address");
	chk_sram_cause: assert property (
		sram_en |-> $past(stk_op != 2'h0)) else $error("stray sram strobe");
	chk_big_pop: assert property (
		s_big_pop |-> ##2 rd_valid) else $error("big pop unanswered");
endmodule // rsd_space_props
bind rsd_register_space rsd_space_props chk_u (.*);
`default_nettype wire

/* File: tb/rsd_sram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rsd_sram_model (
	// sram port
	input wire logic        clk,
	input wire logic        sram_en,
	input wire logic        sram_we,
	input wire logic [15:0] sram_addr,
	input wire logic [7:0]  sram_wdata,
	output var logic [7:0]  sram_rdata
);
	logic [7:0] mem [0:65535];
	// released data toggles each cycle, so a stale byte reads inverted on every other cycle
	always @(posedge clk) begin
		sram_rdata <= ~sram_rdata;
		if (sram_en && sram_we)
			mem[sram_addr] <= sram_wdata;
		else if (sram_en)
			sram_rdata <= mem[sram_addr];
	end
endmodule // rsd_sram_model
`default_nettype wire

/* File: tb/tb_register_space_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_register_space_decoder;
	logic        clk = 0, rst = 1, acc_valid = 0, acc_write = 0, acc_wbit = 0;
	logic        acc_via_reg = 0, sram_en, sram_we, rd_bit, rd_valid;
	logic [1:0]  acc_kind = 0, stk_op = 0, stack_ext;
	logic [2:0]  acc_bit = 0;
	logic [7:0]  acc_addr = 0, acc_wdata = 0, stk_wdata = 0, v;
	logic [7:0]  sram_rdata, sram_wdata, rd_data, stack_pointer;
	logic [15:0] sram_addr, rnd = 16'h8ef2;
	logic [8:0]  exp_q [$];
	int          mismatches = 0, num_checks = 0;
	always #50 clk = ~clk;
	rsd_register_space dut_u (.*);
	rsd_sram_model mem_u (.*);
	function automatic logic [7:0] rand8();
		rnd ^= rnd << 7;
		rnd ^= rnd >> 9;
		rnd ^= rnd << 8;
		return rnd[7:0];
	endfunction
	task automatic acc(input logic [1:0] k, input logic w, s, input logic [7:0] a, d);
		@(posedge clk);
		{acc_valid, stk_op, acc_kind, acc_write, acc_via_reg} <= {1'b1, 2'h0, k, w, s};
		{acc_addr, acc_wdata, acc_wbit, acc_bit} <= {a, d, d[0], a[2:0]};
	endtask
	task automatic rd(input logic [1:0] k, input logic s, input logic [7:0] a, e);
		acc(k, 1'b0, s, a, 8'h00);
		exp_q.push_back({(k == 2'h2) ? e[a[2:0]] : 1'b0, e});
	endtask
	task automatic stk(input logic [1:0] op, input logic [7:0] d);
		@(posedge clk);
		{acc_valid, stk_op, stk_wdata} <= {1'b0, op, d};
		if (op == 2'h2) exp_q.push_back({1'b0, d});
	endtask
	always @(posedge clk) if (rd_valid === 1'b1) begin
		num_checks++;
		if (exp_q.size() == 0 || {rd_bit, rd_data} !== exp_q[0]) begin
			$display("CHECK FAILED %0t read data", $time);
			mismatches++;
		end
		if (exp_q.size() > 0) void'(exp_q.pop_front());
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		v = rand8();
		rd(2'h0, 1'b0, 8'h81, 8'h07);
		acc(2'h0, 1'b1, 1'b0, 8'h10, v);
		rd(2'h0, 1'b0, 8'h10, v);
		acc(2'h1, 1'b1, 1'b0, 8'h9a, v);
		acc(2'h0, 1'b1, 1'b0, 8'h9a, ~v);
		rd(2'h1, 1'b0, 8'h9a, v);
		rd(2'h0, 1'b0, 8'h9a, 8'h00);
		acc(2'h0, 1'b1, 1'b0, 8'h21, 8'h00);
		acc(2'h2, 1'b1, 1'b0, 8'h0f, 8'h01);
		rd(2'h0, 1'b0, 8'h21, 8'h80);
		rd(2'h2, 1'b0, 8'h0f, 8'h80);
		acc(2'h0, 1'b1, 1'b0, 8'hd0, 8'h00);
		acc(2'h2, 1'b1, 1'b0, 8'hd3, 8'h01);
		rd(2'h0, 1'b0, 8'hd0, 8'h08);
		rd(2'h2, 1'b0, 8'hd3, 8'h08);
		acc(2'h3, 1'b1, 1'b0, 8'h03, 8'hc4);
		rd(2'h0, 1'b0, 8'h0b, 8'hc4);
		acc(2'h1, 1'b1, 1'b1, 8'h03, v);
		rd(2'h1, 1'b0, 8'hc4, v);
		$display("test map done");
		stk(2'h1, v);
		rd(2'h0, 1'b0, 8'h08, v);
		stk(2'h2, v);
		acc(2'h0, 1'b1, 1'b0, 8'h9d, 8'h04);
		acc(2'h0, 1'b1, 1'b0, 8'h9b, 8'h02);
		stk(2'h1, ~v);
		stk(2'h2, ~v);
		acc(2'h0, 1'b1, 1'b0, 8'hc6, 8'h40);
		stk(2'h1, v);
		stk(2'h2, v);
		stk(2'h0, 8'h00);
		stk(2'h0, 8'h00);
		rd(2'h0, 1'b0, 8'h81, 8'h07);
		stk(2'h0, 8'h00);
		for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
		if (exp_q.size() > 0) begin
			$display("CHECK FAILED %0t answer missing", $time);
			mismatches++;
		end
		$display("test stack done");
		wrap_up();
	end
endmodule // tb_register_space_decoder
`default_nettype wire
